// ---- l2c_pkg.sv ----
// Constants for the second-level cache setup register and its bus sequencer
// Overview of operation
// R1: Reset loads upper nibble from address straps
// R2: Size field takes inverted A31..A30 levels
// R3: Size codes: none, 256K, 512K, reserved
// R4: Size zero disables the second-level cache
// R5: Software sets L1 enable with nonzero size
// R6: SRAM kind takes inverted A29..A28 levels
// R7: Software writes overwrite strapped fields
// R8: Reset value straps over fixed 0010
// R9: 512K burst: chip select off after next-address
// R10: 512K burst: strobe with final ready if pending
// R11: Disable bit set: next-address never asserted
// R12: Disable clear: size and kind decide next-address
// R13: Software sets disable when pin unconnected
// R14: Software clears disable when pin connected
// R15: L1 enable clear keeps cacheable negated
// R16: Force-miss set makes every lookup miss
// R17: Reads return every field's current value
`default_nettype none

package l2c_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] SETUP_IDX = 8'h52;
  localparam logic [11:0] SETUP_ADDR = {2'b00, SETUP_IDX, 2'b00};

  // ==========================================================
  // Field positions
  localparam int SIZE_LO = 6;
  localparam int KIND_LO = 4;
  localparam int NA_OFF_BIT = 3;
  localparam int FMISS_BIT = 1;
  localparam int L1EN_BIT = 0;

  // ==========================================================
  // Reset values
  localparam logic [3:0] UPPER_RESET = 4'h0;
  localparam logic [3:0] LOWER_RESET = 4'h2;

  // ==========================================================
  // Field encodings
  localparam logic [1:0] SIZE_NONE = 2'h0;
  localparam logic [1:0] SIZE_256K = 2'h1;
  localparam logic [1:0] SIZE_512K = 2'h2;
  localparam logic [1:0] SIZE_RSVD = 2'h3;
  localparam logic [1:0] KIND_PBURST = 2'h0;

  // ==========================================================
  // Host cycle timing, in clocks
  localparam int LEAD_CYCLES = 2;
  localparam int BURST_BEATS = 4;

endpackage

`default_nettype wire

// ---- strap_sampler.sv ----
// Synchroniser and one-shot capture of the reset-time cache straps
`timescale 1ns/1ns
`default_nettype none

module strap_sampler
  import l2c_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Strap pins
  input wire logic [3:0] strap_pins,
  // Captured value
  output logic load,
  output logic [3:0] value
);

  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic pend_r;

  // Left unreset so the pins are already settled at release
  always_ff @(posedge ref_clk) begin
    sync1_r <= strap_pins;
    sync2_r <= sync1_r;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_r <= 1'b1;
      load <= 1'b0;
      value <= UPPER_RESET;
    end else begin
      pend_r <= 1'b0;
      load <= pend_r;
      if (pend_r) begin
        value <= ~sync2_r; // see R2 see R6
      end
    end
  end

endmodule

`default_nettype wire

// ---- apb_port.sv ----
// APB slave front end for the cache setup register
`timescale 1ns/1ns
`default_nettype none

module apb_port
  import l2c_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Register side
  input wire logic [7:0] rd_value,
  output logic wr_stb,
  output logic [7:0] wr_data
);

  logic hit;
  logic setup;

  assign hit = (paddr == SETUP_ADDR);
  assign setup = psel & ~penable;
  assign wr_stb = psel & penable & pready & pwrite & hit & ~pslverr;
  assign wr_data = pwdata[7:0];

  // Fixed one wait-free access phase: ready on the first access cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      if (setup & hit & ~pwrite) begin
        prdata <= {24'h0, rd_value}; // see R17
      end else begin
        prdata <= 32'h0;
      end
    end
  end

endmodule

`default_nettype wire

// ---- l2_cache_ctl.sv ----
// Second-level cache setup register with host cycle and cache SRAM sequencing
`timescale 1ns/1ns
`default_nettype none

module l2_cache_ctl
  import l2c_pkg::*;
#(
  parameter int LEAD = LEAD_CYCLES,
  parameter int BEATS = BURST_BEATS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Strap pins, host address 31..28
  input wire logic [3:0] host_addr_strap,
  // Host bus
  input wire logic host_addr_strobe_n,
  input wire logic cycle_cacheable,
  input wire logic tag_match,
  output logic next_addr_n,
  output logic burst_ready_n,
  output logic cacheable_n,
  output logic l2_hit,
  // Cache SRAM
  output logic cache_chip_sel_n,
  output logic cache_addr_strobe_n
);

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_LEAD = 3'b010,
    S_DATA = 3'b100
  } seq_e;

  // Wide enough for the longest lead or burst count
  typedef logic [3:0] cnt_t;

  // ==========================================================
  // Register fields
  logic [1:0] l2_size_field;
  logic [1:0] l2_sram_kind_field;
  logic next_addr_disable;
  logic l2_force_miss;
  logic l1_cache_enable;
  logic [7:0] l2_cache_setup;

  // Strap capture and bus write strobes
  logic strap_load;
  logic [3:0] strap_value;
  logic wr_stb;
  logic [7:0] wr_data;

  // ==========================================================
  // Derived modes
  // Decoded straight from the fields; every user of them is registered
  logic l2_on;
  logic mode_512pb;
  logic na_allow;

  // ==========================================================
  // Sequencer state
  seq_e state_r;
  seq_e state_nxt;
  cnt_t cnt_r;
  cnt_t cnt_nxt;
  // Marks a pipelined cycle waiting behind the current one
  logic pipe_r;
  logic pipe_nxt;
  logic na_done_r;
  logic ads_seen;
  logic last_beat;

  // ==========================================================
  // Decode helpers
  // Counters run down to zero, so they load one less than the length
  function automatic cnt_t count_of(input int n);
    count_of = cnt_t'(n - 1);
  endfunction

  // True only for the two fitted sizes
  function automatic logic size_valid(input logic [1:0] s);
    size_valid = (s == SIZE_256K) || (s == SIZE_512K);
  endfunction

  function automatic logic is_pburst(input logic [1:0] k);
    is_pburst = (k == KIND_PBURST);
  endfunction

  // ==========================================================
  // Front ends
  // Straps reach the register two clocks after reset is released
  strap_sampler u_strap (
    .ref_clk(ref_clk),
    .rst(rst),
    .strap_pins(host_addr_strap),
    .load(strap_load),
    .value(strap_value)
  );

  // The port answers every access in one clock and never adds waits
  apb_port u_apb (
    .ref_clk(ref_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rd_value(l2_cache_setup),
    .wr_stb(wr_stb),
    .wr_data(wr_data)
  );

  // ==========================================================
  // Setup register
  // Bit 2 is reserved and reads zero
  // Reads show what each field holds now, strapped or written
  assign l2_cache_setup = {l2_size_field, l2_sram_kind_field, next_addr_disable,
                           1'b0, l2_force_miss, l1_cache_enable}; // see R17

  // A write wins over the one-shot strap load if both land in one clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      l2_size_field <= UPPER_RESET[3:2]; // see R8
      l2_sram_kind_field <= UPPER_RESET[1:0];
      next_addr_disable <= LOWER_RESET[NA_OFF_BIT];
      l2_force_miss <= LOWER_RESET[FMISS_BIT];
      l1_cache_enable <= LOWER_RESET[L1EN_BIT];
    end else if (wr_stb) begin
      l2_size_field <= wr_data[SIZE_LO +: 2]; // see R7
      l2_sram_kind_field <= wr_data[KIND_LO +: 2];
      next_addr_disable <= wr_data[NA_OFF_BIT];
      l2_force_miss <= wr_data[FMISS_BIT];
      l1_cache_enable <= wr_data[L1EN_BIT];
    end else if (strap_load) begin
      {l2_size_field, l2_sram_kind_field} <= strap_value; // see R1 see R2 see R6
    end
  end

  // ==========================================================
  // Mode decode
  // Reserved size code is treated like an absent cache
  assign l2_on = size_valid(l2_size_field); // see R3 see R4
  assign mode_512pb = (l2_size_field == SIZE_512K) &&
                      is_pburst(l2_sram_kind_field);
  // Pipelining only pays with burst SRAMs, which take an address ahead of data
  assign na_allow = ~next_addr_disable & l2_on &&
                    is_pburst(l2_sram_kind_field); // see R11 see R12

  // ==========================================================
  // Host cycle sequencer
  // Idle, then LEAD clocks of lead, then BEATS clocks of burst ready.
  // A strobe seen after next-address while busy, before the final beat, is a
  // pipelined cycle: it starts its lead right after the final beat instead of going idle.
  // A strobe while busy but before next-address is ignored; the processor
  // must not issue one.
  assign ads_seen = ~host_addr_strobe_n;
  assign last_beat = (state_r == S_DATA) && (cnt_r == 4'h0);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pipe_nxt = pipe_r;
    case (state_r)
      S_IDLE: begin
        if (ads_seen) begin
          state_nxt = S_LEAD;
          cnt_nxt = count_of(LEAD);
        end
      end
      S_LEAD: begin
        if (cnt_r == 4'h0) begin
          state_nxt = S_DATA;
          cnt_nxt = count_of(BEATS);
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      S_DATA: begin
        if (cnt_r == 4'h0) begin
          if (pipe_r) begin
            state_nxt = S_LEAD;
            cnt_nxt = count_of(LEAD);
          end else begin
            state_nxt = S_IDLE;
          end
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      default: begin
        // Unused one-hot codes fall back to idle
        state_nxt = S_IDLE;
        cnt_nxt = 4'h0;
      end
    endcase
    // A strobe landing on the last beat sets the pipelined flag while the sequencer goes idle
    if (last_beat && pipe_r) begin
      pipe_nxt = 1'b0;
    end
    if (state_r != S_IDLE && na_done_r && ads_seen) begin
      pipe_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      cnt_r <= 4'h0;
      pipe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pipe_r <= pipe_nxt;
    end
  end

  // ==========================================================
  // Next-address: one pulse early in each cycle
  // Pipelined cycles get their own pulse; na_done_r remembers it so that a
  // later strobe is taken as pipelined
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      next_addr_n <= 1'b1;
      na_done_r <= 1'b0;
    end else begin
      if (state_nxt == S_LEAD && state_r != S_LEAD && na_allow) begin
        next_addr_n <= 1'b0; // see R11 see R12
        na_done_r <= 1'b1;
      end else begin
        next_addr_n <= 1'b1;
        if (state_nxt == S_IDLE) begin
          na_done_r <= 1'b0;
        end else if (state_nxt == S_LEAD && state_r == S_DATA) begin
          na_done_r <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Burst ready and cache address strobe
  // Every cycle is run as a full burst of BEATS beats
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      burst_ready_n <= 1'b1;
      cache_addr_strobe_n <= 1'b1;
    end else begin
      burst_ready_n <= ~(state_nxt == S_DATA);
      // Aligned with the final ready only while a pipelined cycle waits
      cache_addr_strobe_n <= ~(mode_512pb && state_nxt == S_DATA &&
                               cnt_nxt == 4'h0 && pipe_nxt); // see R10
    end
  end

  // ==========================================================
  // Cache chip select
  // Only the 512K burst mode toggles the select; other fitted modes hold it
  // on. After a next-address with no pipelined strobe behind it the select
  // stays off until the next pipelined strobe.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cache_chip_sel_n <= 1'b1;
    end else if (!l2_on) begin
      cache_chip_sel_n <= 1'b1; // see R4
    end else if (!mode_512pb) begin
      cache_chip_sel_n <= 1'b0;
    end else if (state_r != S_IDLE && na_done_r && ads_seen) begin
      cache_chip_sel_n <= 1'b0; // see R9
    end else if (!next_addr_n) begin
      cache_chip_sel_n <= 1'b1; // see R9
    end
  end

  // ==========================================================
  // Cacheability and hit detection
  // Registered, so both trail their inputs by one clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cacheable_n <= 1'b1;
      l2_hit <= 1'b0;
    end else begin
      cacheable_n <= ~(l1_cache_enable & cycle_cacheable); // see R15
      l2_hit <= tag_match & l2_on & ~l2_force_miss; // see R16
    end
  end

endmodule

`default_nettype wire

// ---- l2c_assertions.sv ----
// Checker for the cache setup register and host sequencing
`timescale 1ns/1ns
`default_nettype none

module l2c_assertions
  import l2c_pkg::*;
#(
  parameter int LEAD = 2,
  parameter int BEATS = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Straps and host bus
  input wire logic [3:0] host_addr_strap,
  input wire logic host_addr_strobe_n,
  input wire logic cycle_cacheable,
  input wire logic tag_match,
  input wire logic next_addr_n,
  input wire logic burst_ready_n,
  input wire logic cacheable_n,
  input wire logic l2_hit,
  input wire logic cache_chip_sel_n,
  input wire logic cache_addr_strobe_n
);
  // ====
  // Shadow of written value; strap loads are not tracked, so checks that use the shadow wait for a write
  logic [7:0] shd_r;
  logic known_r, calm_r, wr, vsz, m512;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shd_r <= 8'h02;
      known_r <= 1'b0;
      calm_r <= 1'b0;
    end else begin
      calm_r <= known_r && !wr;
      if (wr) begin
        shd_r <= pwdata[7:0] & 8'hfb;
        known_r <= 1'b1;
      end
    end
  end
  assign vsz = shd_r[7:6] == SIZE_256K || shd_r[7:6] == SIZE_512K;
  assign m512 = calm_r && shd_r[7:6] == SIZE_512K && shd_r[5:4] == KIND_PBURST
    && !shd_r[NA_OFF_BIT];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ====
  // Properties
  sequence s_beats; !burst_ready_n [*4] ##1 burst_ready_n; endsequence
  sequence s_last; !burst_ready_n ##1 burst_ready_n; endsequence
  property p_acc; psel && !penable |=> pready; endproperty
  property p_beats; $fell(burst_ready_n) |-> s_beats; endproperty
  property p_nosize; calm_r && !vsz |-> cache_chip_sel_n; endproperty
  property p_csoff; m512 && !next_addr_n |=> cache_chip_sel_n; endproperty
  property p_cson;
    m512 && !host_addr_strobe_n && !$past(next_addr_n) |=> !cache_chip_sel_n;
  endproperty
  property p_strobe; m512 && !cache_addr_strobe_n |-> s_last; endproperty
  property p_na_off; calm_r && shd_r[NA_OFF_BIT] |-> next_addr_n; endproperty
  property p_naok;
    calm_r && !next_addr_n |-> vsz && shd_r[5:4] == KIND_PBURST;
  endproperty
  property p_cacheable;
    calm_r |-> cacheable_n == !(shd_r[L1EN_BIT] && $past(cycle_cacheable));
  endproperty
  property p_hit;
    calm_r |-> l2_hit == ($past(tag_match) && vsz && !shd_r[FMISS_BIT]);
  endproperty
  property p_rd; pready && !pwrite && !pslverr && calm_r |-> prdata == {24'h0, shd_r};
  endproperty
  a_acc: assert property (p_acc) else $error("no access answer");
  a_beats: assert property (p_beats) else $error("burst length wrong");
  a_nosize: assert property (p_nosize) else $error("chip select without cache");
  a_csoff: assert property (p_csoff) else $error("chip select kept");
  a_cson: assert property (p_cson) else $error("chip select not back");
  a_strobe: assert property (p_strobe) else $error("strobe not on final ready");
  a_na_off: assert property (p_na_off) else $error("next address while disabled");
  a_naok: assert property (p_naok) else $error("next address not allowed");
  a_cacheable: assert property (p_cacheable) else $error("cacheable wrong");
  a_hit: assert property (p_hit) else $error("hit wrong");
  a_rd: assert property (p_rd) else $error("read value wrong");
endmodule

bind l2_cache_ctl l2c_assertions #(.LEAD(LEAD), .BEATS(BEATS)) i_l2c_assertions (.*);

`default_nettype wire

// ---- host_cpu_model.sv ----
// Processor model issuing address strobes, with one optional pipelined cycle
`timescale 1ns/1ns
`default_nettype none

module host_cpu_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Test control
  input wire logic start,
  input wire logic pipe,
  // Host bus
  input wire logic next_addr_n,
  output logic host_addr_strobe_n
);
  logic done_r;
  // Pipelined strobe follows next-address at once, the fastest a processor reacts
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      host_addr_strobe_n <= 1'b1;
      done_r <= 1'b0;
    end else begin
      host_addr_strobe_n <= !(start || (pipe && !next_addr_n && !done_r));
      done_r <= !start && (done_r || (pipe && !next_addr_n));
    end
  end
endmodule

`default_nettype wire

// ---- l2_cache_ctl_test.sv ----
// Self-checking bench for the cache setup register and host sequencing
`timescale 1ns/1ns
`default_nettype none

module l2_cache_ctl_test
  import l2c_pkg::*;
;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, start = 0, pipe = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, host_addr_strobe_n, cycle_cacheable = 0, tag_match = 0;
  logic [3:0] host_addr_strap = 4'h6;
  logic next_addr_n, burst_ready_n, cacheable_n, l2_hit, cache_chip_sel_n;
  logic cache_addr_strobe_n;
  int n_errors = 0, check_count = 0, na, br, ca;
  // Row: write, readback, hit, cacheable_n, pipe, next-addr count (3 skips), beats, strobes,
  // chip select before the cycle
  // Nonzero sizes keep l1 enable set; disable is set in rows 1, 4 and 7 only.
  logic [26:0] rows [8] = '{
    {8'hc5, 8'hc1, 1'h0, 1'h0, 1'h0, 2'h0, 4'h4, 1'h0, 1'h1},
    {8'h4b, 8'h4b, 1'h0, 1'h0, 1'h0, 2'h0, 4'h4, 1'h0, 1'h0},
    {8'h81, 8'h81, 1'h1, 1'h0, 1'h1, 2'h3, 4'h8, 1'h1, 1'h0},
    {8'h81, 8'h81, 1'h1, 1'h0, 1'h0, 2'h1, 4'h4, 1'h0, 1'h1},
    {8'h3e, 8'h3a, 1'h0, 1'h1, 1'h0, 2'h0, 4'h4, 1'h0, 1'h1},
    {8'h41, 8'h41, 1'h1, 1'h0, 1'h0, 2'h1, 4'h4, 1'h0, 1'h0},
    {8'h91, 8'h91, 1'h1, 1'h0, 1'h0, 2'h0, 4'h4, 1'h0, 1'h0},
    {8'h89, 8'h89, 1'h1, 1'h0, 1'h1, 2'h0, 4'h4, 1'h0, 1'h0}};

  l2_cache_ctl i_l2_cache_ctl (.*);
  host_cpu_model i_host_cpu_model (.*);

  initial forever #25 ref_clk = ~ref_clk;

  // ====
  // Tasks
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    // Request stands until pready is seen high at a rising edge
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task host(input logic p, input logic [1:0] e_na, input logic [3:0] e_br, input logic e_ca);
    @(posedge ref_clk);
    start <= 1;
    pipe <= p;
    @(posedge ref_clk);
    start <= 0;
    na = 0;
    br = 0;
    ca = 0;
    repeat (24) begin
      @(negedge ref_clk);
      na += !next_addr_n;
      br += !burst_ready_n;
      ca += !cache_addr_strobe_n;
    end
    if (e_na != 2'h3) chk("next_addr", na, e_na);
    chk("beats", br, e_br);
    chk("cache strobe", ca, e_ca);
  endtask

  task wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ====
  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 0;
    repeat (4) @(posedge ref_clk);
    apb(0, SETUP_ADDR, 32'h0);
    chk("strap reset", rd, 32'h92);
    apb(1, 12'h14c, 32'hff);
    chk("unmapped err", er, 32'h1);
    apb(0, 12'h14c, 32'h0);
    chk("unmapped data", rd, 32'h0);
    apb(0, SETUP_ADDR, 32'h0);
    chk("after unmapped", rd, 32'h92);
    $display("test reset and map done");
    cycle_cacheable <= 1;
    tag_match <= 1;
    foreach (rows[i]) begin
      apb(1, SETUP_ADDR, {24'h0, rows[i][26:19]});
      apb(0, SETUP_ADDR, 32'h0);
      chk("readback", rd, rows[i][18:11]);
      @(negedge ref_clk);
      chk("l2_hit", l2_hit, rows[i][10]);
      chk("cacheable_n", cacheable_n, rows[i][9]);
      chk("chip select", cache_chip_sel_n, rows[i][0]);
      host(rows[i][8], rows[i][7:6], rows[i][5:2], rows[i][1]);
      $display("test row %0d done", i);
    end
    // Mid-run reset with the other strap pattern
    @(posedge ref_clk);
    rst <= 1;
    host_addr_strap <= 4'h9;
    @(negedge ref_clk);
    chk("reset select", cache_chip_sel_n, 1'b1);
    chk("reset next_addr", next_addr_n, 1'b1);
    repeat (4) @(posedge ref_clk);
    rst <= 0;
    repeat (4) @(posedge ref_clk);
    apb(0, SETUP_ADDR, 32'h0);
    chk("strap again", rd, 32'h62);
    $display("test mid reset done");
    wrap_up();
  end

  // Tests take about 310 cycles; the limit of 8000 cycles is over 25 times that
  initial begin
    #400000;
    n_errors++;
    wrap_up();
  end
endmodule

`default_nettype wire
